// file: rtl/pmc_pkg.sv
/*
 * Package for the panel mode control and bank select block: switch bundle,
 * mode state type, timing counts.
 * Assumes one 10 MHz clock and processor timing pulses sampled as levels.
 */
package pmc_pkg;

	localparam int unsigned CLK_NS        = 100;
	// Shorter window answers presses faster but tolerates less bounce
	localparam int unsigned DEBOUNCE_US   = 1000;
	localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_US * 1000) / CLK_NS;
	localparam int unsigned DB_W          = 16;
	localparam logic [1:0]  IDLE_LIMIT    = 2'h3;
	localparam logic [1:0]  SC_EXECUTE    = 2'h1;
	localparam logic [1:0]  SC_DMA        = 2'h2;
	localparam int unsigned BANK_SHIFT    = 4;
	localparam int unsigned NUM_BANKS     = 16;
	localparam logic [7:0]  ADDR_RST      = 8'h00;

	typedef struct packed {
		logic load;
		logic reset;
		logic run_prog;
		logic run_util;
		logic step_mode;
	} pmc_sw_s;

	localparam int unsigned SW_W = 5;

	typedef enum logic [1:0] {
		PMC_RESET = 2'b00,
		PMC_RUN   = 2'b01,
		PMC_HALT  = 2'b11,
		PMC_LOAD  = 2'b10
	} pmc_mode_e;

endpackage

// file: rtl/pmc_panel_mode_control.sv
/*
 * Panel mode control and bank select: turns debounced panel and hand-held
 * terminal switches into the processor hold/init lines, detects idle,
 * releases idle with one output DMA request, latches and decodes the high
 * address byte into sixteen bank selects.
 * Assumes switches and backplane inputs are asynchronous; processor state
 * code and timing pulses come from a slower processor and are synchronised.
 */
// Functional notes
// RQ1 - Load switch drives hold and init both active.
// RQ2 - Reset switch drives init active with hold inactive.
// RQ3 - Either run switch releases hold and init.
// RQ4 - Run-utility asserts utility start force on the backplane.
// RQ5 - Step mode: one machine cycle per run press, halt between pulses.
// RQ6 - External hold and init inputs ORed into the control lines.
// RQ7 - Three or more consecutive execute states turn the run lamp off.
// RQ8 - Run-program during idle issues exactly one output DMA request.
// RQ9 - Run lamp lights again once execution resumes.
// RQ10 - Hand-held terminal switches act in parallel with panel switches.
// RQ11 - Every switch contact is debounced before use.
// RQ12 - First timing pulse captures low address byte as high address.
// RQ13 - One-of-16 decoder gives 4 KB bank selects, bank zero at 0000.
// RQ14 - Utility start force makes the decoder see the top bit set.
// RQ15 - Active-low deselect input suppresses all bank selects.
// RQ16 - Processor supplies two timing pulses and a state code per cycle.
// RQ17 - Idle counter clears on any non-execute cycle.
// RQ18 - Step needs release and re-press of the run switch.
`timescale 1ns/10ps

module pmc_panel_mode_control
	import pmc_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	input  wire pmc_sw_s              i_panel_sw,
	input  wire pmc_sw_s              i_term_sw,
	input  wire logic                 i_external_hold_in,
	input  wire logic                 i_external_init_in,
	input  wire logic                 i_timing_pulse_a,
	input  wire logic                 i_timing_pulse_b,
	input  wire logic                 i_state_code_bit0_n,
	input  wire logic                 i_state_code_bit1_n,
	input  wire logic [7:0]           i_addr_low,
	input  wire logic                 i_bank_deselect_n,
	output logic                      o_hold_n,
	output logic                      o_init_n,
	output logic                      o_run_n,
	output logic                      o_output_dma_request_n,
	output logic                      o_utility_start_force,
	output logic [7:0]                o_addr_high,
	output logic [NUM_BANKS-1:0]      o_bank_select_lines
);

	// Two-flop synchronisers for every asynchronous input
	localparam int unsigned SYN_W = 2 * SW_W + 7;
	logic [SYN_W-1:0] sync1_ff;
	logic [SYN_W-1:0] sync2_ff;
	wire  [SYN_W-1:0] raw_in = {i_panel_sw, i_term_sw, i_external_hold_in,
		i_external_init_in, i_timing_pulse_a, i_timing_pulse_b,
		i_state_code_bit0_n, i_state_code_bit1_n, i_bank_deselect_n};

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
		end
	end

	wire pmc_sw_s s_panel   = sync2_ff[SYN_W-1 -: SW_W];
	wire pmc_sw_s s_term    = sync2_ff[SYN_W-SW_W-1 -: SW_W];
	wire          s_ext_hold = sync2_ff[6];
	wire          s_ext_init = sync2_ff[5];
	wire          s_tpa      = sync2_ff[4];
	wire          s_tpb      = sync2_ff[3];
	wire [1:0]    s_sc       = ~{sync2_ff[1], sync2_ff[2]};
	wire          s_desel_n  = sync2_ff[0];

	// Address byte crosses like the pulse a that qualifies it
	logic [7:0] addr_sync1_ff;
	logic [7:0] addr_sync2_ff;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			addr_sync1_ff <= ADDR_RST;
			addr_sync2_ff <= ADDR_RST;
		end
		else
		begin
			addr_sync1_ff <= i_addr_low;
			addr_sync2_ff <= addr_sync1_ff;
		end
	end

	// Terminal switches paralleled with panel switches
	wire pmc_sw_s sw_raw = s_panel | s_term; // RQ10

	// Debounce: a switch changes only after a stable run of DEBOUNCE_CYC
	pmc_sw_s          sw_ff;
	logic [DB_W-1:0]  db_cnt_ff;
	wire              sw_differs = (sw_raw != sw_ff);
	wire              db_done = (db_cnt_ff == DB_W'(DEBOUNCE_CYC - 1));
	wire [DB_W-1:0]   nxt_db_cnt = sw_differs ? (db_done ? '0 :
		db_cnt_ff + DB_W'(1)) : '0;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sw_ff     <= '0;
			db_cnt_ff <= '0;
		end
		else
		begin
			db_cnt_ff <= nxt_db_cnt; // RQ11
			if (sw_differs && db_done)
				sw_ff <= sw_raw; // RQ11
		end
	end

	// Edge detection on debounced run switches and synchronised timing pulses
	logic run_prev_ff;
	wire  run_any  = sw_ff.run_prog | sw_ff.run_util;
	wire  run_rise = run_any & ~run_prev_ff; // RQ18
	logic tpa_prev_ff;
	logic tpb_prev_ff;
	wire  tpa_rise = s_tpa & ~tpa_prev_ff;
	wire  tpb_rise = s_tpb & ~tpb_prev_ff;

	// Mode state machine
	pmc_mode_e mode_ff;
	pmc_mode_e nxt_mode;
	logic      step_grant_ff;
	logic      force_ff;

	always_comb
	begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PMC_RESET, PMC_LOAD, PMC_RUN, PMC_HALT:
			begin
				if (sw_ff.load)
					nxt_mode = PMC_LOAD; // RQ1
				else if (sw_ff.reset)
					nxt_mode = PMC_RESET; // RQ2
				else if (run_rise)
					nxt_mode = PMC_RUN; // RQ3
				else if (mode_ff == PMC_LOAD)
					nxt_mode = PMC_HALT;
				else if (mode_ff == PMC_RUN && sw_ff.step_mode
					&& !step_grant_ff && tpa_rise)
					nxt_mode = PMC_HALT; // RQ5
			end
			default:
				nxt_mode = PMC_RESET;
		endcase
	end

	// Step grant: one TIMING_PULSE_B passes after a press, the next TIMING_PULSE_A halts
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mode_ff       <= PMC_RESET;
			run_prev_ff   <= 1'b0;
			tpa_prev_ff   <= 1'b0;
			tpb_prev_ff   <= 1'b0;
			step_grant_ff <= 1'b0;
			force_ff      <= 1'b0;
		end
		else
		begin
			mode_ff     <= nxt_mode;
			run_prev_ff <= run_any;
			tpa_prev_ff <= s_tpa;
			tpb_prev_ff <= s_tpb;
			if (run_rise)
				step_grant_ff <= 1'b1; // RQ5
			else if (tpb_rise)
				step_grant_ff <= 1'b0; // RQ5
			if (run_rise)
				force_ff <= sw_ff.run_util; // RQ4
			else if (sw_ff.reset || sw_ff.load)
				force_ff <= 1'b0;
		end
	end

	wire mode_hold = (mode_ff == PMC_LOAD) || (mode_ff == PMC_HALT);
	wire mode_init = (mode_ff == PMC_LOAD) || (mode_ff == PMC_RESET);
	assign o_hold_n = ~(mode_hold | s_ext_hold); // RQ1 RQ6
	assign o_init_n = ~(mode_init | s_ext_init); // RQ2 RQ6
	assign o_utility_start_force = force_ff; // RQ4

	// Idle detector and release by one output DMA request
	logic [1:0] idle_cnt_ff;
	logic       idle_ff;
	logic       dma_req_ff;
	wire        is_exec = (s_sc == SC_EXECUTE);
	wire        is_dma  = (s_sc == SC_DMA);
	wire        idle_now = (idle_cnt_ff == IDLE_LIMIT);
	wire        run_p_rise = run_rise & sw_ff.run_prog;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			idle_cnt_ff <= '0;
			idle_ff     <= 1'b0;
			dma_req_ff  <= 1'b0;
		end
		else
		begin
			if (tpa_rise)
			begin
				if (!is_exec)
					idle_cnt_ff <= '0; // RQ17
				else if (!idle_now)
					idle_cnt_ff <= idle_cnt_ff + 2'h1; // RQ7
			end
			if (idle_now)
				idle_ff <= 1'b1; // RQ7
			else
				idle_ff <= 1'b0; // RQ9
			if (idle_ff && run_p_rise)
				dma_req_ff <= 1'b1; // RQ8
			else if (is_dma || mode_init)
				dma_req_ff <= 1'b0; // RQ8
		end
	end

	assign o_run_n = ~((mode_ff == PMC_RUN) && !idle_ff); // RQ7 RQ9
	assign o_output_dma_request_n = ~dma_req_ff; // RQ8

	// High address latch and bank decode
	logic [7:0] addr_high_ff;
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			addr_high_ff <= ADDR_RST;
		else if (tpa_rise)
			addr_high_ff <= addr_sync2_ff; // RQ12
	end
	assign o_addr_high = addr_high_ff;

	wire [3:0] bank_idx = addr_high_ff[7:BANK_SHIFT] | {force_ff, 3'h0}; // RQ14
	assign o_bank_select_lines = s_desel_n ?
		(NUM_BANKS'(1) << bank_idx) : '0; // RQ13 RQ15

	AST_DESELECT: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ15
		!s_desel_n |-> o_bank_select_lines == '0)
		else $error("bank select active while deselected");
	AST_FORCE_TOP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ14
		(force_ff && s_desel_n) |-> o_bank_select_lines[15:8] != '0)
		else $error("forced top bit not decoded");
	AST_ONEHOT: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ13
		s_desel_n |-> $onehot(o_bank_select_lines))
		else $error("bank select not one-hot");
	AST_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ12
		tpa_rise |=> o_addr_high == $past(addr_sync2_ff))
		else $error("high address not captured");
	AST_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ1
		sw_ff.load |=> (!o_hold_n && !o_init_n))
		else $error("load mode not driven");
	AST_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ2
		(sw_ff.reset && !sw_ff.load && !s_ext_hold) |=>
		(!o_init_n && (o_hold_n || s_ext_hold)))
		else $error("reset mode not driven");
	AST_RUN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ3
		(run_rise && !sw_ff.load && !sw_ff.reset) |=>
		((o_hold_n || s_ext_hold) && (o_init_n || s_ext_init)))
		else $error("run mode not driven");
	AST_EXT: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ6
		s_ext_hold |-> !o_hold_n)
		else $error("external hold ignored");
	AST_IDLE_LAMP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ7
		idle_now |=> o_run_n)
		else $error("run lamp lit during idle");
	AST_ONE_DMA: assert property (@(posedge i_clk) disable iff (!i_rstn) // RQ8
		$rose(dma_req_ff) |-> $past(idle_ff))
		else $error("output DMA request outside idle");

endmodule // pmc_panel_mode_control

// file: bench/pmc_cpu_model.sv
/*
 * Processor side model: timing pulses, state code and address byte.
 * Assumes the bench calls cycle_run and keeps its own inputs off posedge.
 */
`timescale 1ns/10ps
module pmc_cpu_model
(
	input  wire logic       i_clk,
	output logic            o_tpa,
	output logic            o_tpb,
	output logic            o_state_code_bit0_n,
	output logic            o_state_code_bit1_n,
	output logic [7:0]      o_addr
);
	initial
	begin
		o_tpa = 1'h0;
		o_tpb = 1'h0;
		o_state_code_bit0_n = 1'h1;
		o_state_code_bit1_n = 1'h1;
		o_addr = 8'h00;
	end

	// Pulses last five clocks, like a slow processor, so sync flops see them
	task automatic cycle_run(input logic [1:0] code, input logic [7:0] hi);
		@(negedge i_clk);
		{o_state_code_bit1_n, o_state_code_bit0_n} = ~code;
		o_addr = hi;
		o_tpa = 1'h1;
		repeat (5) @(negedge i_clk);
		o_tpa = 1'h0;
		o_addr = ~hi;
		repeat (8) @(negedge i_clk);
		o_tpb = 1'h1;
		repeat (5) @(negedge i_clk);
		o_tpb = 1'h0;
		repeat (4) @(negedge i_clk);
	endtask
endmodule // pmc_cpu_model

// file: bench/tb.sv
/*
 * Self-checking bench for the panel mode control and bank select block.
 * Assumes pmc_pkg and the processor model are compiled first.
 */
`timescale 1ns/10ps
module tb;
	import pmc_pkg::*;
	logic                 i_clk;
	logic                 i_rstn;
	pmc_sw_s              i_panel_sw;
	pmc_sw_s              i_term_sw;
	logic                 i_external_hold_in;
	logic                 i_external_init_in;
	logic                 i_bank_deselect_n;
	logic                 timing_pulse_a, timing_pulse_b, state_code_bit0_n, state_code_bit1_n;
	logic [7:0]           addr;
	logic                 o_hold_n, o_init_n, o_run_n;
	logic                 o_output_dma_request_n;
	logic                 o_utility_start_force;
	logic [7:0]           o_addr_high;
	logic [NUM_BANKS-1:0] o_bank_select_lines;
	int                   mismatches = 0;
	int                   samples_checked = 0;
	localparam int unsigned WAIT_MAX = DEBOUNCE_CYC + 2000;

	pmc_panel_mode_control DUT (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_panel_sw(i_panel_sw), .i_term_sw(i_term_sw),
		.i_external_hold_in(i_external_hold_in),
		.i_external_init_in(i_external_init_in),
		.i_timing_pulse_a(timing_pulse_a), .i_timing_pulse_b(timing_pulse_b),
		.i_state_code_bit0_n(state_code_bit0_n), .i_state_code_bit1_n(state_code_bit1_n),
		.i_addr_low(addr), .i_bank_deselect_n(i_bank_deselect_n),
		.o_hold_n(o_hold_n), .o_init_n(o_init_n), .o_run_n(o_run_n),
		.o_output_dma_request_n(o_output_dma_request_n),
		.o_utility_start_force(o_utility_start_force),
		.o_addr_high(o_addr_high),
		.o_bank_select_lines(o_bank_select_lines));

	pmc_cpu_model cpu (.i_clk(i_clk), .o_tpa(timing_pulse_a), .o_tpb(timing_pulse_b),
		.o_state_code_bit0_n(state_code_bit0_n), .o_state_code_bit1_n(state_code_bit1_n), .o_addr(addr));

	always #50 i_clk = ~i_clk;

	task automatic test_done();
		$display("mismatches %0d checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Debounce is long, so the bound covers one full debounce window
	task automatic wait_mode(input logic h, input logic i);
		int n;
		n = 0;
		while (!(o_hold_n === h && o_init_n === i) && n < WAIT_MAX)
		begin
			@(negedge i_clk);
			n++;
		end
		chk("mode", {14'h0, h, i}, {14'h0, o_hold_n, o_init_n});
		if (n >= WAIT_MAX)
		begin
			mismatches++;
			test_done();
		end
	endtask

	task automatic t_banks();
		logic [7:0] hi [3] = '{8'h00, 8'h5a, 8'hf3};
		foreach (hi[k])
		begin
			cpu.cycle_run(2'h0, hi[k]);
			chk("addr_high", {8'h00, hi[k]}, {8'h00, o_addr_high});
			chk("banks", 16'h0001 << hi[k][7:4], o_bank_select_lines);
		end
		i_bank_deselect_n = 1'h0;
		repeat (4) @(negedge i_clk);
		chk("deselect", 16'h0000, o_bank_select_lines);
		i_bank_deselect_n = 1'h1;
	endtask

	task automatic t_run_util();
		i_term_sw.run_util = 1'h1;
		repeat (100) @(negedge i_clk);
		chk("init_early", 16'h0000, {15'h0, o_init_n});
		wait_mode(1'h1, 1'h1);
		chk("force", 16'h0001, {15'h0, o_utility_start_force});
		chk("lamp_on", 16'h0000, {15'h0, o_run_n});
		cpu.cycle_run(2'h0, 8'h21);
		chk("util_bank", 16'h0400, o_bank_select_lines);
		i_external_hold_in = 1'h1;
		i_external_init_in = 1'h1;
		repeat (4) @(negedge i_clk);
		chk("ext_on", 16'h0000, {14'h0, o_hold_n, o_init_n});
		i_external_hold_in = 1'h0;
		i_external_init_in = 1'h0;
		repeat (4) @(negedge i_clk);
		chk("ext_off", 16'h0003, {14'h0, o_hold_n, o_init_n});
		repeat (2) cpu.cycle_run(2'h1, 8'h21);
		chk("not_idle", 16'h0000, {15'h0, o_run_n});
		cpu.cycle_run(2'h1, 8'h21);
		chk("idle_lamp", 16'h0001, {15'h0, o_run_n});
		cpu.cycle_run(2'h0, 8'h21);
		chk("resume", 16'h0000, {15'h0, o_run_n});
	endtask

	// Idle released by a run-program press: one output DMA request
	task automatic t_idle_dma();
		int n;
		i_term_sw.run_util = 1'h0;
		repeat (3) cpu.cycle_run(2'h1, 8'h21);
		chk("idle_again", 16'h0001, {15'h0, o_run_n});
		repeat (DEBOUNCE_CYC + 10) @(negedge i_clk);
		i_panel_sw.run_prog = 1'h1;
		n = 0;
		while (o_output_dma_request_n !== 1'h0 && n < WAIT_MAX)
		begin
			@(negedge i_clk);
			n++;
		end
		chk("dma_req", 16'h0000, {15'h0, o_output_dma_request_n});
		chk("force_off", 16'h0000, {15'h0, o_utility_start_force});
		if (n >= WAIT_MAX)
		begin
			mismatches++;
			test_done();
		end
		cpu.cycle_run(2'h2, 8'h21);
		chk("dma_done", 16'h0001, {15'h0, o_output_dma_request_n});
		chk("lamp_back", 16'h0000, {15'h0, o_run_n});
		cpu.cycle_run(2'h0, 8'h21);
		chk("dma_once", 16'h0001, {15'h0, o_output_dma_request_n});
	endtask

	// Step mode: one machine cycle per fresh run press
	task automatic t_step();
		i_panel_sw.run_prog = 1'h0;
		i_panel_sw.step_mode = 1'h1;
		repeat (DEBOUNCE_CYC + 10) @(negedge i_clk);
		cpu.cycle_run(2'h0, 8'h21);
		chk("step_halt", 16'h0001, {14'h0, o_hold_n, o_init_n});
		i_panel_sw.run_prog = 1'h1;
		wait_mode(1'h1, 1'h1);
		cpu.cycle_run(2'h0, 8'h22);
		chk("step_one", 16'h0003, {14'h0, o_hold_n, o_init_n});
		cpu.cycle_run(2'h0, 8'h23);
		chk("step_stop", 16'h0001, {14'h0, o_hold_n, o_init_n});
		cpu.cycle_run(2'h0, 8'h24);
		chk("step_held", 16'h0001, {14'h0, o_hold_n, o_init_n});
	endtask

	task automatic t_load();
		i_panel_sw.run_prog = 1'h0;
		i_panel_sw.step_mode = 1'h0;
		i_panel_sw.load = 1'h1;
		wait_mode(1'h0, 1'h0);
		chk("force_clr", 16'h0000, {15'h0, o_utility_start_force});
		chk("no_dma", 16'h0001, {15'h0, o_output_dma_request_n});
	endtask

	initial
	begin
		i_clk = 1'h0;
		i_rstn = 1'h0;
		i_panel_sw = '0;
		i_term_sw = '0;
		i_external_hold_in = 1'h0;
		i_external_init_in = 1'h0;
		i_bank_deselect_n = 1'h1;
		repeat (3) @(negedge i_clk);
		chk("reset_out", 16'h000b, {o_addr_high, o_utility_start_force,
			3'h0, o_hold_n, o_init_n, o_run_n, o_output_dma_request_n});
		repeat (2) @(negedge i_clk);
		i_rstn = 1'h1;
		t_banks();
		t_run_util();
		t_idle_dma();
		t_step();
		t_load();
		test_done();
	end
endmodule // tb
